//--- rtl/codec_ctl_pkg.sv
// constants and types for the codec serial control block
// Overview of operation
// - select, clock, data in configure; three-state data out returns results
// - with select low, data in sampled on each rising serial clock
// - first 1 bit after chip select falls is bit 7 of control byte
// - zero bits before the start bit change nothing
// - byte with bit 7 clear ignored unless expected DAC data
// - enable bits act regardless of address bits
// - bit 0 enables the DAC
// - bit 1 enables the ADC
// - bit 2 enables the reference; no effect on supply-reference variant
// - bit 3 set selects continuous conversions until reconfigured or chip select next falls
// - bit 3 clear: one conversion per control word
// - bit 4 routes half supply, else external analog input, to ADC
// - bit 5 addresses ADC; result shifted out after 36us conversion
// - bit 5 clear: ADC keeps power state but never converts
// - bit 6 addresses DAC; following eight bits are DAC data
// - DAC output updates only after eighth data bit, double buffered
// - bit 6 clear: DAC ignores serial data
// - serial output changes on falling serial clock edges
// - chip select high: inputs ignored, data out high impedance
// - chip select rising mid first control byte after select falls forces full shutdown state
// - single mode conversion starts at falling edge of last control bit
`default_nettype none
package codec_ctl_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CONV_TIME_NS = 36000;
    localparam int CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
    localparam int BIT_DAC_ON = 0;
    localparam int BIT_ADC_ON = 1;
    localparam int BIT_REF_ON = 2;
    localparam int BIT_REPEAT = 3;
    localparam int BIT_MUX = 4;
    localparam int BIT_ADC_SEL = 5;
    localparam int BIT_DAC_SEL = 6;
    localparam int BIT_START = 7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    typedef struct packed {
        logic dacSelectBit;
        logic adcSelectBit;
        logic inputMuxBit;
        logic repeatModeBit;
        logic referenceOnBit;
        logic adcOnBit;
        logic dacOnBit;
    } ctrl_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic din;
    } serial_in_t;

    typedef enum logic [3:0] {
        ST_HUNT = 4'h1,
        ST_CTRL = 4'h2,
        ST_DATA = 4'h4,
        ST_IDLE = 4'h8
    } rx_state_t;
endpackage
`default_nettype wire

//--- rtl/codec_serial_control.sv
// serial control logic of the 8-bit ADC and DAC codec
`default_nettype none
module codec_serial_control
    import codec_ctl_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES,
    parameter bit SUPPLY_REF = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire serial_in_t serIn,
    output logic doutO,
    output logic doutOeN,
    output ctrl_t ctrl_r,
    output logic [7:0] dacOut_r,
    output logic convBusy_r,
    input wire logic [7:0] adcResult
);
    // two-flop synchronisers; stage one read only by stage two
    serial_in_t meta_r, sync_r, prev_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
            sync_r <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
            prev_r <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
        end else begin
            meta_r <= serIn;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic active, sclkRise, sclkFall, csFall, csRise;
    assign active = !sync_r.csN;
    assign sclkRise = active && sync_r.sclk && !prev_r.sclk;
    assign sclkFall = active && !sync_r.sclk && prev_r.sclk;
    assign csFall = !sync_r.csN && prev_r.csN;
    assign csRise = sync_r.csN && !prev_r.csN;

    rx_state_t state_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] byteIn;
    logic byteDone;
    assign byteIn = {shift_r[6:0], sync_r.din};
    assign byteDone = sclkRise && bitCnt_r == LAST_BIT;
    logic ctrlDone;
    // byte-aligned after the first control word; bit 7 marks a new one
    assign ctrlDone = byteDone && (state_r == ST_CTRL
                      || (state_r == ST_IDLE && byteIn[BIT_START]));

    // pending conversion start, taken on the falling edge after the byte
    logic startPend_r, contOn_r;
    logic [7:0] outSh_r;
    logic [2:0] outCnt_r;
    logic outValid_r;
    logic [$clog2(CONV_COUNT+1)-1:0] convCnt_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_HUNT;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
        end else if (csFall) begin
            state_r <= ST_HUNT;
            bitCnt_r <= 3'h0;
        end else if (sclkRise) begin
            case (state_r)
                ST_HUNT: begin
                    // zeros before start leave framing alone
                    if (sync_r.din) begin
                        state_r <= ST_CTRL;
                        bitCnt_r <= 3'h1;
                        shift_r <= 8'h01;
                    end
                end
                ST_IDLE: begin
                    // cleared-msb bytes pass through unused
                    shift_r <= byteIn;
                    bitCnt_r <= bitCnt_r + 3'h1;
                    if (ctrlDone && byteIn[BIT_DAC_SEL])
                        state_r <= ST_DATA;
                end
                ST_CTRL, ST_DATA: begin
                    shift_r <= byteIn;
                    bitCnt_r <= bitCnt_r + 3'h1;
                    if (byteDone) begin
                        if (state_r == ST_CTRL && byteIn[BIT_DAC_SEL])
                            state_r <= ST_DATA;
                        else if (state_r == ST_DATA && contOn_r
                                 && ctrl_r.dacSelectBit)
                            state_r <= ST_DATA;
                        else
                            state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_HUNT;
            endcase
        end
    end

    // control word register; aborted first control byte forces full shutdown
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= ctrl_t'(CTRL_RESET[6:0]);
        end else if (csRise && state_r == ST_CTRL) begin
            ctrl_r <= ctrl_t'(CTRL_RESET[6:0]);
        end else if (ctrlDone) begin
            // enables taken whatever the address bits say
            ctrl_r.dacOnBit <= byteIn[BIT_DAC_ON];
            ctrl_r.adcOnBit <= byteIn[BIT_ADC_ON];
            ctrl_r.referenceOnBit <= SUPPLY_REF ? 1'b0
                                   : byteIn[BIT_REF_ON];
            ctrl_r.repeatModeBit <= byteIn[BIT_REPEAT];
            ctrl_r.inputMuxBit <= byteIn[BIT_MUX];
            ctrl_r.adcSelectBit <= byteIn[BIT_ADC_SEL];
            ctrl_r.dacSelectBit <= byteIn[BIT_DAC_SEL];
        end
    end

    // only a full data byte reaches the dac latch
    always_ff @(posedge clk) begin
        if (rst)
            dacOut_r <= 8'h00;
        else if (byteDone && state_r == ST_DATA)
            dacOut_r <= byteIn;
    end

    // continuous flag cleared when the next frame starts
    always_ff @(posedge clk) begin
        if (rst || csFall)
            contOn_r <= 1'b0;
        else if (ctrlDone)
            contOn_r <= byteIn[BIT_REPEAT] && byteIn[BIT_ADC_SEL];
    end

    always_ff @(posedge clk) begin
        if (rst || csFall)
            startPend_r <= 1'b0;
        else if (ctrlDone)
            startPend_r <= byteIn[BIT_ADC_SEL]
                           && byteIn[BIT_ADC_ON];
        else if (byteDone && state_r == ST_DATA && contOn_r)
            startPend_r <= 1'b1;
        else if (sclkFall)
            startPend_r <= 1'b0;
    end

    logic convStart, convEnd, lastOutFall;
    // single mode: one start per control word
    // continuous mode also restarts on the falling edge of the last result bit
    assign convStart = (startPend_r && sclkFall || lastOutFall && contOn_r)
        && !convBusy_r;
    assign convEnd = convBusy_r && convCnt_r == 1;

    // conversion timed by clk, never by the serial clock
    always_ff @(posedge clk) begin
        if (rst) begin
            convBusy_r <= 1'b0;
            convCnt_r <= '0;
        end else if (convStart) begin
            convBusy_r <= 1'b1;
            convCnt_r <= ($clog2(CONV_COUNT+1))'(CONV_COUNT);
        end else if (convBusy_r) begin
            convCnt_r <= convCnt_r - 1'b1;
            if (convEnd)
                convBusy_r <= 1'b0;
        end
    end

    // output shifter; partial result survives a chip select toggle
    always_ff @(posedge clk) begin
        if (rst) begin
            outSh_r <= 8'h00;
            outCnt_r <= 3'h0;
            outValid_r <= 1'b0;
        end else if (convEnd) begin
            outSh_r <= adcResult;
            outCnt_r <= 3'h0;
            outValid_r <= 1'b1;
        end else if (outValid_r && sclkFall && sync_r.sclk == 1'b0) begin
            outSh_r <= {outSh_r[6:0], 1'b0};
            outCnt_r <= outCnt_r + 3'h1;
            if (outCnt_r == LAST_BIT)
                outValid_r <= 1'b0;
        end
    end

    assign lastOutFall = outValid_r && sclkFall && outCnt_r == LAST_BIT;
    // continuous mode restarts on the last result bit
    logic restart_r;
    always_ff @(posedge clk) begin
        if (rst)
            restart_r <= 1'b0;
        else
            restart_r <= lastOutFall && contOn_r;
    end

    // pin drive; first bit needs no edge, it sits at the msb
    always_ff @(posedge clk) begin
        if (rst) begin
            doutO <= 1'b0;
            doutOeN <= 1'b1;
        end else begin
            doutO <= outValid_r ? outSh_r[7] : 1'b0;
            doutOeN <= sync_r.csN;
        end
    end

    // conversion sequencing
    continuous_restart_a: assert property (
        @(posedge clk) disable iff (rst)
        (restart_r && !$past(convBusy_r))
        |-> convBusy_r)
        else $error("continuous conversion did not restart");

    conv_length_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(convBusy_r)
        |-> convBusy_r [*8])
        else $error("conversion ended too early");

    start_edge_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(convBusy_r)
        |-> $past(sclkFall))
        else $error("conversion not started on falling edge");

    single_once_a: assert property (
        @(posedge clk) disable iff (rst)
        (lastOutFall && !contOn_r && !startPend_r && !convBusy_r)
        |=> !convBusy_r)
        else $error("single mode converted again");

    no_addr_conv_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && !byteIn[BIT_ADC_SEL])
        |=> !startPend_r)
        else $error("conversion armed without address");

    // result path on the data out pin; state held while deselected
    result_load_a: assert property (
        @(posedge clk) disable iff (rst)
        convEnd
        |=> outValid_r && outSh_r == $past(adcResult))
        else $error("result not loaded at conversion end");

    shift_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (outValid_r && !sclkFall && !convEnd)
        |=> $stable(outSh_r))
        else $error("result shifted without falling edge");

    hiz_idle_a: assert property (
        @(posedge clk) disable iff (rst)
        sync_r.csN
        |=> doutOeN)
        else $error("data out driven while deselected");

    oe_drive_a: assert property (
        @(posedge clk) disable iff (rst)
        !sync_r.csN
        |=> !doutOeN)
        else $error("data out not driven while selected");

    inactive_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (sync_r.csN && prev_r.csN)
        |=> $stable(ctrl_r) && $stable(dacOut_r))
        else $error("state changed while deselected");

    // dac latch
    dac_update_a: assert property (
        @(posedge clk) disable iff (rst)
        (dacOut_r != $past(dacOut_r))
        |-> $past(state_r) == ST_DATA)
        else $error("dac updated outside data byte");

    dac_ignore_a: assert property (
        @(posedge clk) disable iff (rst)
        (byteDone && state_r == ST_IDLE)
        |=> $stable(dacOut_r))
        else $error("dac took an unaddressed byte");

    dac_sel_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && !csFall && byteIn[BIT_DAC_SEL])
        |=> state_r == ST_DATA)
        else $error("dac address did not expect data");

    // control word fields
    dac_on_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && byteIn[BIT_DAC_ON])
        |=> ctrl_r.dacOnBit)
        else $error("dac enable not taken");

    adc_on_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && byteIn[BIT_ADC_ON])
        |=> ctrl_r.adcOnBit)
        else $error("adc enable not taken");

    enable_free_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && !byteIn[BIT_ADC_SEL] && !byteIn[BIT_DAC_SEL]
         && byteIn[BIT_ADC_ON])
        |=> ctrl_r.adcOnBit)
        else $error("enable ignored without address");

    ref_on_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && byteIn[BIT_REF_ON] && !SUPPLY_REF)
        |=> ctrl_r.referenceOnBit)
        else $error("reference enable not taken");

    repeat_bit_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && byteIn[BIT_REPEAT])
        |=> ctrl_r.repeatModeBit)
        else $error("conversion mode not taken");

    mux_bit_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrlDone && byteIn[BIT_MUX])
        |=> ctrl_r.inputMuxBit)
        else $error("mux select not taken");

    abort_shut_a: assert property (
        @(posedge clk) disable iff (rst)
        (csRise && state_r == ST_CTRL)
        |=> ctrl_r == '0)
        else $error("aborted control byte did not shut down");

    // framing
    zero_lead_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_r == ST_HUNT && sclkRise && !sync_r.din && !csFall)
        |=> state_r == ST_HUNT && $stable(ctrl_r))
        else $error("leading zero changed state");

    lead_one_a: assert property (
        @(posedge clk) disable iff (rst)
        (state_r == ST_HUNT && sclkRise && sync_r.din && !csFall)
        |=> state_r == ST_CTRL && bitCnt_r == 3'h1)
        else $error("start bit not taken as bit 7");

    bit_count_a: assert property (
        @(posedge clk) disable iff (rst)
        (sclkRise && state_r == ST_CTRL && !csFall)
        |=> bitCnt_r == $past(bitCnt_r) + 3'h1)
        else $error("control bit not counted");

    frame_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        csFall
        |=> state_r == ST_HUNT && bitCnt_r == 3'h0)
        else $error("framing not cleared");
endmodule
`default_nettype wire

//--- tb/serial_host_model.sv
// serial bus master model driving the codec control pins
`default_nettype none
module serial_host_model
    import codec_ctl_pkg::*;
(
    input wire logic clk,
    output serial_in_t serIn,
    input wire logic doutO
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 6;
    logic q;
    initial serIn = '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data set in low phase, sampled by both sides at the rise
    task automatic xfer_bit(input logic b, output logic r);
        serIn.din = b;
        wait_clk(HALF);
        r = doutO;
        serIn.sclk = 1'b1;
        wait_clk(HALF);
        serIn.sclk = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(v[i], q);
        end
    endtask
    task automatic read_byte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b0, v[i]);
        end
    endtask
    task automatic frame_begin();
        serIn.csN = 1'b0;
        wait_clk(HALF);
    endtask
    // released data line flips so a stale level is never trusted
    task automatic frame_end();
        wait_clk(HALF);
        serIn.csN = 1'b1;
        serIn.din = ~serIn.din;
        wait_clk(HALF);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the codec serial control block
`default_nettype none
module testbench
    import codec_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    serial_in_t serIn;
    logic doutO;
    logic doutOeN;
    ctrl_t ctrl;
    logic [7:0] dacOut;
    logic busy;
    logic [7:0] adcResult;
    logic [7:0] rd;
    logic q;
    int fail_count = 0;
    int total_checks = 0;
    always #2 clk = ~clk;
    codec_serial_control #(.CONV_COUNT(CONV), .SUPPLY_REF(1'b0))
        u_codec_serial_control (.clk(clk), .rst(rst), .serIn(serIn),
        .doutO(doutO), .doutOeN(doutOeN), .ctrl_r(ctrl),
        .dacOut_r(dacOut), .convBusy_r(busy), .adcResult(adcResult));
    serial_host_model u_serial_host_model (.clk(clk), .serIn(serIn),
        .doutO(doutO));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        settle(60000);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        adcResult = 8'h96;
        settle(16);
        rst = 1'b0;
        settle(4);
        check({busy, ctrl}, 8'h00);
        check({dacOut[6:0], doutOeN}, 8'h01);
        // leading zeros, DAC control, data, then a non-start byte
        u_serial_host_model.frame_begin();
        for (int i = 0; i < 3; i++) u_serial_host_model.xfer_bit(1'b0, q);
        check({1'b0, ctrl}, 8'h00);
        u_serial_host_model.send_byte(8'hc7);
        settle(6);
        check({1'b0, ctrl}, 8'h47);
        for (int i = 7; i > 0; i--) u_serial_host_model.xfer_bit(i[0], q);
        settle(6);
        check(dacOut, 8'h00);
        u_serial_host_model.xfer_bit(1'b0, q);
        settle(6);
        check(dacOut, 8'haa);
        u_serial_host_model.send_byte(8'h33);
        settle(6);
        check({1'b0, ctrl}, 8'h47);
        u_serial_host_model.frame_end();
        u_serial_host_model.frame_begin();
        u_serial_host_model.send_byte(8'h81);
        u_serial_host_model.send_byte(8'h24);
        settle(6);
        check(dacOut, 8'haa);
        u_serial_host_model.frame_end();
        // clocks and ones while deselected, then each enable combination with DAC data
        u_serial_host_model.send_byte(8'hff);
        check({1'b0, ctrl}, 8'h01);
        check({7'h00, doutOeN}, 8'h01);
        for (int e = 0; e < 8; e++) begin
            u_serial_host_model.frame_begin();
            u_serial_host_model.send_byte(8'hc0 | e[7:0]);
            u_serial_host_model.send_byte(8'h5a);
            settle(6);
            check({busy, ctrl}, {5'h08, e[2:0]});
            u_serial_host_model.frame_end();
        end
        // aborted DAC data, then aborted control byte
        u_serial_host_model.frame_begin();
        u_serial_host_model.send_byte(8'hc3);
        for (int i = 0; i < 4; i++) u_serial_host_model.xfer_bit(1'b1, q);
        u_serial_host_model.frame_end();
        check(dacOut, 8'h5a);
        u_serial_host_model.frame_begin();
        for (int i = 0; i < 4; i++) u_serial_host_model.xfer_bit(i < 2, q);
        u_serial_host_model.frame_end();
        settle(6);
        check({1'b0, ctrl}, 8'h00);
        // mux change, acquisition wait, single conversion
        u_serial_host_model.frame_begin();
        u_serial_host_model.send_byte(8'h96);
        settle(900);
        u_serial_host_model.send_byte(8'hb6);
        settle(6);
        check({busy, ctrl}, 8'hb6);
        settle(CONV + 10);
        check({7'h00, busy}, 8'h00);
        u_serial_host_model.read_byte(rd);
        check(rd, 8'h96);
        check({7'h00, doutOeN}, 8'h00);
        u_serial_host_model.read_byte(rd);
        check({7'h00, busy}, 8'h00);
        u_serial_host_model.frame_end();
        check({7'h00, doutOeN}, 8'h01);
        // continuous conversions with a changing result
        adcResult = 8'h3c;
        u_serial_host_model.frame_begin();
        u_serial_host_model.send_byte(8'hae);
        settle(CONV + 10);
        u_serial_host_model.read_byte(rd);
        check(rd, 8'h3c);
        settle(6);
        check({7'h00, busy}, 8'h01);
        adcResult = 8'hc3;
        settle(CONV + 10);
        u_serial_host_model.read_byte(rd);
        check(rd, 8'hc3);
        u_serial_host_model.frame_end();
        print_verdict();
    end
endmodule
`default_nettype wire
